// *** verilog/dss_pkg.sv ***
// constants, states and delay decoding for the dual-axis safety stop unit
`default_nettype none

package dss_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // clock and time base
    localparam int SYS_CLK_KHZ    = 200000;
    localparam int TICK_MS        = 1;
    localparam int MS_TICK_CYCLES = SYS_CLK_KHZ * TICK_MS;
    localparam int TICK_W         = 18;

    // redundant input disagreement filter, milliseconds
    localparam int DISC_FILTER_MS = 10;

    ////////////////////////////////////////////////////////////////////////////
    // delay figures in milliseconds
    localparam int DLY_W = 16;
    localparam logic [DLY_W-1:0] DLY_0_MS    = 16'h0000;
    localparam logic [DLY_W-1:0] DLY_1P4_MS  = 16'h0578;
    localparam logic [DLY_W-1:0] DLY_2P8_MS  = 16'h0af0;
    localparam logic [DLY_W-1:0] DLY_5P6_MS  = 16'h15e0;
    localparam logic [DLY_W-1:0] DLY_9P8_MS  = 16'h2648;
    localparam logic [DLY_W-1:0] DLY_30P8_MS = 16'h7850;

    localparam int SW_W     = 4;
    localparam int NUM_AXIS = 2;
    localparam int AXIS_A   = 0;
    localparam int AXIS_B   = 1;

    ////////////////////////////////////////////////////////////////////////////
    // per-axis sequence
    typedef enum logic [1:0] {
        ST_TORQUE_OFF = 2'b00,
        ST_DRIVE      = 2'b01,
        ST_STOP_DELAY = 2'b10
    } dss_state_t;

    // switch value to {axis A delay, axis B delay}
    function automatic logic [2*DLY_W-1:0] dss_delay_pair(input logic [SW_W-1:0] code);
        logic [2*DLY_W-1:0] pair;
        pair = {DLY_0_MS, DLY_0_MS};
        case (code)
            4'h0: pair = {DLY_0_MS,    DLY_0_MS};
            4'h1: pair = {DLY_0_MS,    DLY_1P4_MS};
            4'h2: pair = {DLY_0_MS,    DLY_2P8_MS};
            4'h3: pair = {DLY_0_MS,    DLY_9P8_MS};
            4'h4: pair = {DLY_0_MS,    DLY_30P8_MS};
            4'h5: pair = {DLY_1P4_MS,  DLY_2P8_MS};
            4'h6: pair = {DLY_1P4_MS,  DLY_9P8_MS};
            4'h7: pair = {DLY_1P4_MS,  DLY_30P8_MS};
            4'h8: pair = {DLY_2P8_MS,  DLY_2P8_MS};
            4'h9: pair = {DLY_2P8_MS,  DLY_9P8_MS};
            4'ha: pair = {DLY_2P8_MS,  DLY_30P8_MS};
            4'hb: pair = {DLY_5P6_MS,  DLY_9P8_MS};
            4'hc: pair = {DLY_5P6_MS,  DLY_30P8_MS};
            4'hd: pair = {DLY_9P8_MS,  DLY_9P8_MS};
            4'he: pair = {DLY_9P8_MS,  DLY_30P8_MS};
            4'hf: pair = {DLY_30P8_MS, DLY_30P8_MS};
            default: pair = {DLY_0_MS, DLY_0_MS};
        endcase
        return pair;
    endfunction : dss_delay_pair

endpackage : dss_pkg

`default_nettype wire

// *** verilog/dss_safety_stop.sv ***
// dual-axis safety stop logic: delayed torque-off outputs and indicators
`timescale 1ns/10ps
`default_nettype none

module dss_safety_stop #(
    parameter int P_MS_TICK_CYCLES = dss_pkg::MS_TICK_CYCLES
) (
    input  wire logic                     i_clk_sys,
    input  wire logic                     i_rst_b,
    input  wire logic [1:0]               i_start_reset_input,
    input  wire logic [1:0]               i_shutoff_input_one,
    input  wire logic [1:0]               i_shutoff_input_two,
    input  wire logic [dss_pkg::SW_W-1:0] i_delay_switch_one,
    input  wire logic [dss_pkg::SW_W-1:0] i_delay_switch_two,
    output logic      [1:0]               o_safe_output_one,
    output logic      [1:0]               o_safe_output_two,
    output logic      [1:0]               o_led_start_reset,
    output logic      [1:0]               o_led_shutoff_one,
    output logic      [1:0]               o_led_shutoff_two,
    output logic      [1:0]               o_led_torque_off_state,
    output logic      [1:0]               o_led_safe_output_one,
    output logic      [1:0]               o_led_safe_output_two,
    output logic      [1:0]               o_led_fault,
    output logic                          o_delay_match_indicator
);

    ////////////////////////////////////////////////////////////////////////////
    // millisecond time base shared by both axes

    localparam logic [dss_pkg::TICK_W-1:0] TICK_LAST = dss_pkg::TICK_W'(P_MS_TICK_CYCLES - 1);

    logic [dss_pkg::TICK_W-1:0] tick_cnt;
    wire                        ms_tick = (tick_cnt == TICK_LAST);

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= ms_tick ? '0 : tick_cnt + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // delay switch capture at power-up

    logic                     cfg_valid;
    logic [dss_pkg::SW_W-1:0] cfg_one;
    logic [dss_pkg::SW_W-1:0] cfg_two;

    // capture once
    // reset loads constants only; switches are sampled on the first clock after release
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cfg_valid <= 1'b0;
            cfg_one   <= '0;
            cfg_two   <= '0;
        end else if (!cfg_valid) begin
            cfg_valid <= 1'b1;
            cfg_one   <= i_delay_switch_one;
            cfg_two   <= i_delay_switch_two;
        end
    end

    wire cfg_match      = (cfg_one == cfg_two);
    wire cfg_mismatch   = cfg_valid & ~cfg_match;
    // delay decode
    // both switches agree whenever an axis may run, so switch one alone is decoded
    wire [2*dss_pkg::DLY_W-1:0] delay_pair = dss_pkg::dss_delay_pair(cfg_one);

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_delay_match_indicator <= 1'b0;
        end else begin
            o_delay_match_indicator <= cfg_valid & cfg_match;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-axis sequence

    genvar g;
    generate
        for (g = 0; g < dss_pkg::NUM_AXIS; g++) begin : g_axis
            wire [dss_pkg::DLY_W-1:0] axis_delay = (g == dss_pkg::AXIS_A)
                                                 ? delay_pair[2*dss_pkg::DLY_W-1:dss_pkg::DLY_W]
                                                 : delay_pair[dss_pkg::DLY_W-1:0];

            dss_pkg::dss_state_t       state;
            dss_pkg::dss_state_t       next_state;
            logic                      start_reset_input_prev;
            logic                      fault;
            logic [dss_pkg::DLY_W-1:0] dly_cnt;
            logic [dss_pkg::DLY_W-1:0] disc_cnt;

            wire run_ok      = i_shutoff_input_one[g] & i_shutoff_input_two[g];
            wire disagree    = i_shutoff_input_one[g] ^ i_shutoff_input_two[g];
            wire release_evt = start_reset_input_prev & ~i_start_reset_input[g];
            wire disc_trip   = disagree & (disc_cnt >= dss_pkg::DLY_W'(dss_pkg::DISC_FILTER_MS));
            wire next_fault  = fault | disc_trip | cfg_mismatch;
            // one extra tick guarantees at least the full delay despite tick phase
            wire dly_done    = ms_tick & (dly_cnt >= axis_delay);

            always_comb begin
                next_state = state;
                case (state)
                    dss_pkg::ST_TORQUE_OFF: begin
                        if (release_evt && run_ok && cfg_valid) begin
                            next_state = dss_pkg::ST_DRIVE;
                        end
                    end
                    dss_pkg::ST_DRIVE: begin
                        if (!run_ok) begin
                            next_state = (axis_delay == dss_pkg::DLY_0_MS)
                                       ? dss_pkg::ST_TORQUE_OFF : dss_pkg::ST_STOP_DELAY;
                        end
                    end
                    dss_pkg::ST_STOP_DELAY: begin
                        if (dly_done) begin
                            next_state = dss_pkg::ST_TORQUE_OFF;
                        end
                    end
                    default: next_state = dss_pkg::ST_TORQUE_OFF;
                endcase
                if (next_fault) begin
                    next_state = dss_pkg::ST_TORQUE_OFF;
                end
            end

            always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    state     <= dss_pkg::ST_TORQUE_OFF;
                    start_reset_input_prev <= 1'b0;
                    fault     <= 1'b0;
                end else begin
                    state     <= next_state;
                    start_reset_input_prev <= i_start_reset_input[g];
                    fault     <= next_fault;
                end
            end

            always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    dly_cnt <= '0;
                end else if (state != dss_pkg::ST_STOP_DELAY) begin
                    dly_cnt <= '0;
                end else if (ms_tick) begin
                    dly_cnt <= dly_cnt + 1'b1;
                end
            end

            always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    disc_cnt <= '0;
                end else if (!disagree) begin
                    disc_cnt <= '0;
                end else if (ms_tick && !disc_trip) begin
                    disc_cnt <= disc_cnt + 1'b1;
                end
            end

            // outputs follow the state being entered so they never lag it
            wire next_drive = (next_state == dss_pkg::ST_DRIVE) | (next_state == dss_pkg::ST_STOP_DELAY);

            always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    o_safe_output_one[g]      <= 1'b0;
                    o_safe_output_two[g]      <= 1'b0;
                    o_led_torque_off_state[g] <= 1'b1;
                    o_led_safe_output_one[g]  <= 1'b1;
                    o_led_safe_output_two[g]  <= 1'b1;
                    o_led_start_reset[g]      <= 1'b0;
                    o_led_shutoff_one[g]      <= 1'b0;
                    o_led_shutoff_two[g]      <= 1'b0;
                    o_led_fault[g]            <= 1'b0;
                end else begin
                    o_safe_output_one[g]      <= next_drive;
                    o_safe_output_two[g]      <= next_drive;
                    o_led_torque_off_state[g] <= ~next_drive;
                    o_led_safe_output_one[g]  <= ~next_drive;
                    o_led_safe_output_two[g]  <= ~next_drive;
                    o_led_start_reset[g]      <= i_start_reset_input[g];
                    o_led_shutoff_one[g]      <= ~i_shutoff_input_one[g];
                    o_led_shutoff_two[g]      <= ~i_shutoff_input_two[g];
                    o_led_fault[g]            <= next_fault;
                end
            end
        end
    endgenerate

endmodule : dss_safety_stop

`default_nettype wire

// *** test/dss_safety_stop_properties.sv ***
// port assertions for the dual-axis safety stop block
`timescale 1ns/10ps
`default_nettype none
module dss_stop_checker #(
    parameter int P_MS_TICK_CYCLES = 4
) (
    input wire logic       i_clk_sys,
    input wire logic       i_rst_b,
    input wire logic [1:0] i_start_reset_input,
    input wire logic [1:0] i_shutoff_input_one,
    input wire logic [1:0] i_shutoff_input_two,
    input wire logic [3:0] i_delay_switch_one,
    input wire logic [3:0] i_delay_switch_two,
    input wire logic [1:0] o_safe_output_one,
    input wire logic [1:0] o_safe_output_two,
    input wire logic [1:0] o_led_start_reset,
    input wire logic [1:0] o_led_shutoff_one,
    input wire logic [1:0] o_led_shutoff_two,
    input wire logic [1:0] o_led_torque_off_state,
    input wire logic [1:0] o_led_safe_output_one,
    input wire logic [1:0] o_led_safe_output_two,
    input wire logic [1:0] o_led_fault,
    input wire logic       o_delay_match_indicator
);
    // one ms of slack for tick phase plus pipeline
    localparam int DISC_MAX = 11 * P_MS_TICK_CYCLES + 3;
    logic [1:0]  age;
    logic [3:0]  cap_one;
    logic [3:0]  cap_two;
    logic [15:0] disc_cnt;
    wire logic   armed;
    assign armed = age == 2'h3;
    // switches copied on the first edge, as the block does
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            age      <= 2'h0;
            cap_one  <= 4'h0;
            cap_two  <= 4'h0;
            disc_cnt <= 16'h0;
        end else begin
            age      <= armed ? age : age + 2'h1;
            cap_one  <= (age == 2'h0) ? i_delay_switch_one : cap_one;
            cap_two  <= (age == 2'h0) ? i_delay_switch_two : cap_two;
            disc_cnt <= (i_shutoff_input_one[0] != i_shutoff_input_two[0]) ? disc_cnt + 16'h1 : 16'h0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    sequence s_release(ax);
        armed && i_start_reset_input[ax] && !o_safe_output_one[ax] && !o_led_fault[ax]
            && i_shutoff_input_one[ax] && i_shutoff_input_two[ax]
        ##1 !i_start_reset_input[ax] && i_shutoff_input_one[ax] && i_shutoff_input_two[ax];
    endsequence
    AST_START_RESET_INPUT_LED: assert property (armed |-> o_led_start_reset == $past(i_start_reset_input))
        else $error("start/reset monitor wrong");
    AST_SHUT_ONE_LED: assert property (armed |-> o_led_shutoff_one == ~$past(i_shutoff_input_one))
        else $error("shut-off one monitor wrong");
    AST_SHUT_TWO_LED: assert property (armed |-> o_led_shutoff_two == ~$past(i_shutoff_input_two))
        else $error("shut-off two monitor wrong");
    AST_TOF_LED: assert property (o_led_torque_off_state == ~o_safe_output_one)
        else $error("torque-off monitor wrong");
    AST_OUT_LED: assert property (o_led_safe_output_one == ~o_safe_output_one
            && o_led_safe_output_two == ~o_safe_output_two)
        else $error("safe output monitor wrong");
    AST_OUT_PAIR: assert property (o_safe_output_one == o_safe_output_two)
        else $error("safe outputs differ");
    AST_MATCH: assert property (armed |-> o_delay_match_indicator == (cap_one == cap_two))
        else $error("match indicator wrong");
    AST_MISMATCH_FAULT: assert property (armed && cap_one != cap_two |-> o_led_fault == 2'h3)
        else $error("mismatch without fault");
    AST_RELEASE_A: assert property (s_release(0) |=> o_safe_output_one[0])
        else $error("release ignored");
    AST_ONLY_RELEASE: assert property ($rose(o_safe_output_one[0]) |->
            $past(i_start_reset_input[0], 2) && !$past(i_start_reset_input[0]))
        else $error("drive without release edge");
    AST_DISAGREE: assert property (disc_cnt > 16'(DISC_MAX) |-> o_led_fault[0] && !o_safe_output_one[0])
        else $error("disagreement not faulted");
    AST_FAULT_STICKY: assert property (!$fell(o_led_fault[0]))
        else $error("fault cleared without reset");
endmodule : dss_stop_checker
bind dss_safety_stop dss_stop_checker #(.P_MS_TICK_CYCLES(P_MS_TICK_CYCLES)) dss_stop_checker_i (
    .i_clk_sys, .i_rst_b, .i_start_reset_input, .i_shutoff_input_one, .i_shutoff_input_two,
    .i_delay_switch_one, .i_delay_switch_two, .o_safe_output_one, .o_safe_output_two, .o_led_start_reset,
    .o_led_shutoff_one, .o_led_shutoff_two, .o_led_torque_off_state, .o_led_safe_output_one,
    .o_led_safe_output_two, .o_led_fault, .o_delay_match_indicator);
`default_nettype wire

// *** test/dss_field_model.sv ***
// field side: shut-off and start/reset contacts plus delay rotary switches
`timescale 1ns/10ps
`default_nettype none
module dss_field_model (
    input  wire logic [1:0] i_trip,
    input  wire logic [1:0] i_split,
    input  wire logic [1:0] i_press,
    input  wire logic [3:0] i_code,
    input  wire logic       i_skew,
    output logic      [1:0] o_sd_one,
    output logic      [1:0] o_sd_two,
    output logic      [1:0] o_start_reset_input,
    output logic      [3:0] o_sw_one,
    output logic      [3:0] o_sw_two
);
    assign o_sw_one = i_code;
    assign o_sw_two = i_code + {3'h0, i_skew};
    // split opens channel one only, a wiring fault
    assign o_sd_one = ~(i_trip | i_split);
    assign o_sd_two = ~i_trip;
    assign o_start_reset_input   = i_press;
endmodule : dss_field_model
`default_nettype wire

// *** test/tb.sv ***
// self-checking bench for the dual-axis safety stop block
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam int T = 2;
    logic            clk_sys = 1'b0;
    logic            rst_b   = 1'b0;
    logic [1:0]      trip    = 2'h0;
    logic [1:0]      split   = 2'h0;
    logic [1:0]      press   = 2'h0;
    logic [3:0]      code    = 4'h0;
    logic            skew    = 1'b0;
    wire logic [1:0] sd_one, sd_two, start_reset_input, safe_one, safe_two, led_start_reset_input, led_sd1, led_sd2;
    wire logic [1:0] led_tof, led_so1, led_so2, fault;
    wire logic [3:0] sw_one, sw_two;
    wire logic       match;
    int              err_total   = 0;
    int              check_count = 0;
    logic [3:0]      codes[4] = '{4'h0, 4'h5, 4'h8, 4'hb};
    int              ms_a[4]  = '{0, 1400, 2800, 5600};
    int              ms_b[4]  = '{0, 2800, 2800, 9800};
    dss_field_model dss_field_model_i (.i_trip(trip), .i_split(split), .i_press(press), .i_code(code),
        .i_skew(skew), .o_sd_one(sd_one), .o_sd_two(sd_two), .o_start_reset_input(start_reset_input), .o_sw_one(sw_one), .o_sw_two(sw_two));
    dss_safety_stop #(.P_MS_TICK_CYCLES(T)) dss_safety_stop_i (.i_clk_sys(clk_sys), .i_rst_b(rst_b),
        .i_start_reset_input(start_reset_input), .i_shutoff_input_one(sd_one), .i_shutoff_input_two(sd_two),
        .i_delay_switch_one(sw_one), .i_delay_switch_two(sw_two), .o_safe_output_one(safe_one),
        .o_safe_output_two(safe_two), .o_led_start_reset(led_start_reset_input), .o_led_shutoff_one(led_sd1),
        .o_led_shutoff_two(led_sd2), .o_led_torque_off_state(led_tof), .o_led_safe_output_one(led_so1),
        .o_led_safe_output_two(led_so2), .o_led_fault(fault), .o_delay_match_indicator(match));
    initial forever #2.5 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : give_verdict
    // switches are only read at power-up, so every setting needs a reset
    // tasks return just after an edge: callers check there, then wait an edge before driving
    task automatic power_up(input logic [3:0] c, input logic k);
        @(posedge clk_sys);
        {rst_b, code, skew, trip, split, press} <= {1'b0, c, k, 6'h0};
        @(posedge clk_sys);
        #1 check("outputs in reset", {safe_one, led_tof}, 4'h3);
        @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
    endtask : power_up
    task automatic release_axes(input logic [1:0] ax);
        @(posedge clk_sys);
        press <= ax;
        repeat (2) @(posedge clk_sys);
        press <= 2'h0;
        #1 check("start/reset led", led_start_reset_input, ax);
        @(posedge clk_sys);
        #1;
    endtask : release_axes
    task automatic run_delay(input logic [3:0] c, input int da, input int db);
        int fa;
        int fb;
        fa = -1;
        fb = -1;
        power_up(c, 1'b0);
        check("match led", {match, fault}, 3'h4);
        release_axes(2'h3);
        check("driving", {safe_one, safe_two, led_tof}, 6'h3c);
        @(posedge clk_sys);
        // switches turned apart after capture must change neither delay nor match
        {code, skew} <= {~c, 1'b1};
        trip <= 2'h3;
        // n counts edges from the one that samples the trip; off after delay plus one tick phase
        for (int n = 0; n < 30000 && (fa < 0 || fb < 0); n++) begin
            @(posedge clk_sys);
            #1;
            if (fa < 0 && !safe_one[0]) fa = n;
            if (fb < 0 && !safe_one[1]) fb = n;
        end
        check("delay a", 16'(fa >= da * T && fa <= da * T + T), 16'h1);
        check("delay b", 16'(fb >= db * T && fb <= db * T + T), 16'h1);
        check("stopped leds", {led_sd1, led_sd2, led_tof, led_so1, led_so2, match, fault}, 13'h1ffc);
    endtask : run_delay
    // longest delay waits about 19600 cycles, the whole run near 31000
    initial begin
        repeat (50000) @(posedge clk_sys);
        err_total++;
        give_verdict();
    end
    initial begin
        for (int i = 0; i < 4; i++) run_delay(codes[i], ms_a[i], ms_b[i]);
        power_up(4'h0, 1'b0);
        @(posedge clk_sys);
        trip <= 2'h2;
        release_axes(2'h3);
        check("open input refuses", safe_one, 2'h1);
        @(posedge clk_sys);
        {trip, split} <= 4'h1;
        repeat (8 * T) @(posedge clk_sys);
        // one open channel already stops axis a; axis b saw no new release edge
        #1 check("within filter", {fault, safe_one}, 4'h0);
        repeat (3 * T + 4) @(posedge clk_sys);
        #1 check("disagreement", {fault, safe_one}, 4'h4);
        power_up(4'h5, 1'b1);
        check("mismatch", {match, fault}, 3'h3);
        release_axes(2'h3);
        check("mismatch refuses", safe_one, 2'h0);
        give_verdict();
    end
endmodule : tb
`default_nettype wire
